/* File: bench/scb_bus_monitor.sv */
// Wire-level checker for the serial control bus between host and target
`timescale 1ns/100ps
module scb_bus_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe
);
  logic scl_q, sda_q, busy_q, first_q, rd_q;
  logic [3:0] cnt_q;

  // Frame tracker: bit count within each nine-bit slot, direction bit
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        busy_q <= 1'b1;
        first_q <= 1'b1;
        rd_q <= 1'b0;
        cnt_q <= 4'h0;
      end else begin
        if (scl && scl_q && !sda_q && sda) busy_q <= 1'b0;
        if (scl && !scl_q) begin
          cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == 4'h8) first_q <= 1'b0;
          if (cnt_q == 4'h7 && first_q) rd_q <= sda;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_open_drain;
    !(dev_scl_o | dev_sda_o | host_scl_o | host_sda_o);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("a wire driver would push high");
  property p_no_stretch;
    !dev_scl_oe;
  endproperty
  a_no_stretch: assert property (p_no_stretch)
    else $error("target pulled the clock wire");
  property p_drive_low;
    $rose(dev_sda_oe) |-> !scl;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("target took data while clock high");
  property p_release_low;
    $fell(dev_sda_oe) |-> !scl;
  endproperty
  a_release_low: assert property (p_release_low)
    else $error("target released data while clock high");
  property p_ack_holds;
    $rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:64] $rose(scl));
  endproperty
  a_ack_holds: assert property (p_ack_holds)
    else $error("target dropped data before clock rise");
  property p_write_ack_only;
    $rose(scl) && !rd_q && dev_sda_oe |-> cnt_q == 4'h8;
  endproperty
  a_write_ack_only: assert property (p_write_ack_only)
    else $error("target drove outside the acknowledge slot");
  property p_read_slot_free;
    $rose(scl) && rd_q && !first_q && cnt_q == 4'h8 |-> !dev_sda_oe;
  endproperty
  a_read_slot_free: assert property (p_read_slot_free)
    else $error("target held the master acknowledge slot");
  property p_idle_quiet;
    !busy_q |-> !dev_sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("target drove data outside a transaction");
  property p_framed;
    $rose(scl) |-> busy_q;
  endproperty
  a_framed: assert property (p_framed)
    else $error("clock pulse outside start and stop");

  c_write_ack: cover property ($rose(scl) && !rd_q && dev_sda_oe);
  c_read_bit: cover property ($rose(scl) && rd_q && !first_q && dev_sda_oe);
  c_stop: cover property (busy_q ##1 !busy_q);
endmodule : scb_bus_monitor

/* File: bench/serial_control_bus_slave_tb.sv */
// Bench joining host and target ends, plus a hand-driven second bus
`timescale 1ns/100ps
module serial_control_bus_slave_tb;
  localparam logic [7:0] LVL [8] = '{8'h00, 8'h30, 8'h50, 8'h70,
    8'h90, 8'hAC, 8'hD0, 8'hFF};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic rw = 1'b0;
  logic [6:0] dev_addr = 7'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] strap = 8'h00;
  logic [6:0] own_addr;
  logic [31:0] regs;
  logic [7:0] rdata;
  logic wr_pulse, host_done, host_nack, aux_arb, aux_busy, host_busy;
  logic dev_busy;
  int error_cnt = 0, total_checks = 0, cyc = 0, wp_cnt = 0, arb_cnt = 0;

  always #20 sys_clk = ~sys_clk;

  scb_if u_bus();
  scb_if u_aux_bus();
  scb_dev_end u_scb_dev_end (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_strap_level(strap), .bus(u_bus), .o_own_addr(own_addr),
    .o_regs(regs), .o_wr_pulse(wr_pulse), .o_arb_lost(), .o_busy(dev_busy));
  // Small quarter count keeps each transfer near a thousand cycles
  scb_host_end #(.QTR_CYCLES(8)) u_scb_host_end (.i_sys_clk(sys_clk),
    .i_rst(rst), .i_req(req), .i_rw(rw), .i_dev_addr(dev_addr),
    .i_reg_addr(reg_addr), .i_wdata(wdata), .bus(u_bus),
    .o_busy(host_busy), .o_done(host_done), .o_nack(host_nack),
    .o_rdata(rdata));
  scb_dev_end u_scb_dev_end_aux (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_strap_level(8'h00), .bus(u_aux_bus), .o_own_addr(), .o_regs(),
    .o_wr_pulse(), .o_arb_lost(aux_arb), .o_busy(aux_busy));
  scb_bus_monitor u_scb_bus_monitor (.i_sys_clk(sys_clk), .i_rst(rst),
    .scl(u_bus.scl), .sda(u_bus.sda), .dev_scl_o(u_bus.dev_scl_o),
    .dev_scl_oe(u_bus.dev_scl_oe), .dev_sda_o(u_bus.dev_sda_o),
    .dev_sda_oe(u_bus.dev_sda_oe), .host_scl_o(u_bus.host_scl_o),
    .host_scl_oe(u_bus.host_scl_oe), .host_sda_o(u_bus.host_sda_o),
    .host_sda_oe(u_bus.host_sda_oe));

  task tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (aux_arb === 1'b1) arb_cnt <= arb_cnt + 1;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task do_reset(input logic [7:0] lvl);
    strap <= lvl;
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : do_reset

  task xfer(input logic r, input logic [6:0] a, input logic [7:0] p,
    input logic [7:0] d);
    logic fin;
    fin = 1'b0;
    wp_cnt = 0;
    req <= 1'b1;
    rw <= r;
    dev_addr <= a;
    reg_addr <= p;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    check(host_busy, 1'b1);
    for (int n = 0; n < 3000 && !fin; n++) begin
      @(posedge sys_clk);
      if (wr_pulse === 1'b1) wp_cnt++;
      fin = (host_done === 1'b1);
    end
    check(fin, 1'b1);
    check({host_busy, dev_busy}, 2'h0);
  endtask : xfer

  //////////////////////////////////////////////////////////////////////////
  task sc_strap_bands;
    logic [6:0] ea;
    logic [7:0] wd;
    ea = 7'h0C;
    for (int i = 0; i < 8; i++) begin
      wd = 8'hA0 + 8'(i);
      do_reset(LVL[i]);
      check(own_addr, ea);
      check(regs[7:0], {ea, 1'b0});
      xfer(1'b0, ea, 8'h01, wd);
      check({host_nack, wp_cnt[3:0], regs[15:8]}, {5'h01, wd});
      xfer(1'b0, ea ^ 7'h40, 8'h01, 8'h5A);
      check({host_nack, regs[15:8]}, {1'b1, wd});
      ea = ea + 7'h02;
    end
    // Strap moves after reset; the address in use must not follow it
    strap <= 8'h00;
    repeat (8) @(posedge sys_clk);
    check(own_addr, 7'h1A);
  endtask : sc_strap_bands

  task sc_regs;
    logic [8:0] ex;
    for (int k = 2; k < 5; k++) begin
      xfer(1'b0, 7'h1A, 8'(k), 8'h50 + 8'(k));
      check(host_nack, 1'b0);
    end
    for (int k = 1; k < 5; k++) begin
      xfer(1'b1, 7'h1A, 8'(k), 8'h00);
      ex = (k == 1) ? 9'h0A7 : (k < 4) ? 9'h050 + 9'(k) : 9'h000;
      check({host_nack, rdata}, ex);
    end
  endtask : sc_regs

  task sc_override;
    xfer(1'b0, 7'h1A, 8'h00, 8'h67);
    check(own_addr, 7'h33);
    xfer(1'b0, 7'h1A, 8'h01, 8'h11);
    check(host_nack, 1'b1);
    xfer(1'b1, 7'h33, 8'h00, 8'h00);
    check({host_nack, rdata}, 9'h067);
    do_reset(8'hFF);
    check({own_addr, regs[7:0]}, {7'h1A, 8'h34});
  endtask : sc_override

  // c high pulls the clock wire low, d high pulls the data wire low
  task bb(input logic c, input logic d);
    u_aux_bus.host_scl_oe <= c;
    u_aux_bus.host_sda_oe <= d;
    repeat (4) @(posedge sys_clk);
  endtask : bb

  task bb_bit(input logic b);
    bb(1'b1, ~b);
    bb(1'b0, ~b);
  endtask : bb_bit

  task sc_arb_loss;
    logic [7:0] ab;
    ab = {7'h0C, 1'b1};
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    for (int k = 7; k >= 0; k--) bb_bit(ab[k]);
    bb_bit(1'b1);
    check(u_aux_bus.sda, 1'b0);
    // Another party holds data low while the target sends its byte
    for (int k = 0; k < 8; k++) bb_bit(1'b0);
    check(arb_cnt, 32'h1);
    check(u_aux_bus.dev_sda_oe, 1'b0);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    check(aux_busy, 1'b0);
  endtask : sc_arb_loss

  initial begin
    u_aux_bus.host_scl_o = 1'b0;
    u_aux_bus.host_sda_o = 1'b0;
    u_aux_bus.host_scl_oe = 1'b0;
    u_aux_bus.host_sda_oe = 1'b0;
    sc_strap_bands();
    sc_regs();
    sc_override();
    sc_arb_loss();
    tally_and_finish();
  end
endmodule : serial_control_bus_slave_tb

/* File: core/scb_dev_end.sv */
// Serial control bus target end with strap-selected address
`timescale 1ns/100ps
module scb_dev_end
  import scb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_strap_level,
  scb_if.dev bus,
  output logic [6:0] o_own_addr,
  output logic [SCB_REG_COUNT*8-1:0] o_regs,
  output logic o_wr_pulse,
  output logic o_arb_lost,
  output logic o_busy
);

  typedef struct packed {
    scb_dev_st_type st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic first;
    logic rd;
    logic sda_oe;
    logic [SCB_REG_COUNT-1:0][7:0] regs;
    logic [6:0] strap_addr;
    logic strap_done;
    logic [2:0][7:0] strap_s;
    logic [1:0] strap_fill;
    logic [6:0] own;
    logic wr_pulse;
    logic arb_lost;
  } scb_dev_state_type;

  scb_dev_state_type q;
  scb_dev_state_type d;

  // Strap stages hold stale reset contents until this many clocks have run
  localparam logic [1:0] STRAP_FILL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [6:0] strap_decode(input logic [7:0] level);
    logic [2:0] band;
    band = 3'h0;
    for (int i = 0; i < SCB_BANDS - 1; i++) begin
      if (level >= SCB_BAND_EDGE[i]) begin
        band = 3'(i + 1);
      end
    end
    return SCB_ADDR_TABLE[band];
  endfunction : strap_decode

  // Pointers beyond the register file read as zero
  function automatic logic [7:0] reg_read(
    input logic [7:0] ptr,
    input logic [SCB_REG_COUNT-1:0][7:0] regs
  );
    if (ptr < 8'(SCB_REG_COUNT)) begin
      return regs[ptr[SCB_REG_IDX_W-1:0]];
    end
    return 8'h00;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic scl_n;
  logic sda_n;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] tx_byte;
  logic [7:0] ptr_inc;

  always_comb begin
    d = q;
    d.wr_pulse = 1'b0;
    d.arb_lost = 1'b0;
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    // A level counts only once the second and third stages agree
    scl_n = (q.scl_s[2] == q.scl_s[1]) ? q.scl_s[2] : q.scl_f;
    sda_n = (q.sda_s[2] == q.sda_s[1]) ? q.sda_s[2] : q.sda_f;
    d.scl_f = scl_n;
    d.sda_f = sda_n;
    scl_rise = scl_n & ~q.scl_f;
    scl_fall = ~scl_n & q.scl_f;
    start_ev = q.scl_f & scl_n & q.sda_f & ~sda_n;
    stop_ev = q.scl_f & scl_n & ~q.sda_f & sda_n;
    ptr_inc = q.ptr + 8'h01;
    tx_byte = 8'h00;

    // Strap pin crosses in through three stages like the bus wires
    d.strap_s = {q.strap_s[1:0], i_strap_level};
    if (q.strap_fill != STRAP_FILL) begin
      d.strap_fill = q.strap_fill + 2'h1;
    end
    // Strap is static; one capture once the stages are full is enough
    if (!q.strap_done && q.strap_fill == STRAP_FILL &&
        q.strap_s[2] == q.strap_s[1]) begin
      d.strap_done = 1'b1;
      d.strap_addr = strap_decode(q.strap_s[2]);
      d.regs[SCB_REG_ID[SCB_REG_IDX_W-1:0]] =
        {strap_decode(q.strap_s[2]), 1'b0};
    end
    d.own = q.regs[SCB_REG_ID[SCB_REG_IDX_W-1:0]][SCB_ID_SEL_BIT] ?
      q.regs[SCB_REG_ID[SCB_REG_IDX_W-1:0]][7:1] : q.strap_addr;

    if (start_ev) begin
      d.st = DS_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      d.st = DS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        DS_IDLE: begin
          d.sda_oe = 1'b0;
        end
        DS_ADDR: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda_n};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == SCB_BYTE_BITS) begin
            if (q.sh[7:1] == q.own) begin
              d.sda_oe = 1'b1;
              d.rd = q.sh[0];
              d.first = 1'b1;
              d.st = DS_AACK;
            end else begin
              d.st = DS_IDLE;
            end
          end
        end
        DS_AACK: begin
          if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.rd == SCB_RW_READ) begin
              tx_byte = reg_read(q.ptr, q.regs);
              d.sh = tx_byte;
              d.sda_oe = ~tx_byte[7];
              d.st = DS_RD;
            end else begin
              d.sda_oe = 1'b0;
              d.st = DS_WR;
            end
          end
        end
        DS_WR: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda_n};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == SCB_BYTE_BITS) begin
            d.sda_oe = 1'b1;
            d.st = DS_WACK;
            if (q.first) begin
              d.ptr = q.sh;
              d.first = 1'b0;
            end else begin
              if (q.ptr < 8'(SCB_REG_COUNT)) begin
                d.regs[q.ptr[SCB_REG_IDX_W-1:0]] = q.sh;
                d.wr_pulse = 1'b1;
              end
              d.ptr = ptr_inc;
            end
          end
        end
        DS_WACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.cnt = 4'h0;
            d.st = DS_WR;
          end
        end
        DS_RD: begin
          if (scl_rise) begin
            // Sending a one yet seeing zero: another driver owns the wire
            if (!q.sda_oe && !sda_n) begin
              d.arb_lost = 1'b1;
              d.st = DS_IDLE;
            end else begin
              d.cnt = q.cnt + 4'h1;
            end
          end else if (scl_fall) begin
            if (q.cnt == SCB_BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st = DS_RACK;
            end else begin
              d.sda_oe = ~q.sh[6];
              d.sh = {q.sh[6:0], 1'b0};
            end
          end
        end
        DS_RACK: begin
          if (scl_rise && sda_n) begin
            d.st = DS_IDLE;
          end else if (scl_fall) begin
            tx_byte = reg_read(ptr_inc, q.regs);
            d.ptr = ptr_inc;
            d.sh = tx_byte;
            d.sda_oe = ~tx_byte[7];
            d.cnt = 4'h0;
            d.st = DS_RD;
          end
        end
        default: begin
          d.st = DS_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= DS_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.regs <= {SCB_REG_COUNT{SCB_REG_RESET}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // The target never stretches the clock, so it leaves that wire alone
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_scl_oe = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = q.sda_oe;
  assign o_own_addr = q.own;
  assign o_regs = q.regs;
  assign o_wr_pulse = q.wr_pulse;
  assign o_arb_lost = q.arb_lost;
  assign o_busy = (q.st != DS_IDLE);

endmodule : scb_dev_end

/* File: core/scb_host_end.sv */
// Serial control bus master end: single-register write and read
`timescale 1ns/100ps
module scb_host_end
  import scb_pkg::*;
#(
  parameter int QTR_CYCLES = SCB_HOST_QTR_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_rw,
  input wire logic [6:0] i_dev_addr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_wdata,
  scb_if.host bus,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);

  typedef struct packed {
    scb_host_st_type st;
    logic [1:0] ph;
    logic [SCB_QCNT_W-1:0] qc;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [2:0] stage;
    logic scl_oe;
    logic sda_oe;
    logic rw;
    logic [6:0] dev;
    logic [7:0] rega;
    logic [7:0] wd;
    logic [7:0] rdata;
    logic ackbit;
    logic done;
    logic nack;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
  } scb_host_state_type;

  scb_host_state_type q;
  scb_host_state_type d;

  localparam logic [SCB_QCNT_W-1:0] QLAST = SCB_QCNT_W'(QTR_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit sequencer

  logic tick;
  logic adv;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    d.scl_f = (q.scl_s[2] == q.scl_s[1]) ? q.scl_s[2] : q.scl_f;
    d.sda_f = (q.sda_s[2] == q.sda_s[1]) ? q.sda_s[2] : q.sda_f;
    tick = (q.qc == QLAST);
    // High phase waits until the wire is really high: stretching
    adv = tick && (q.ph != 2'h1 || q.scl_f);
    if (q.st == HS_IDLE) begin
      d.qc = '0;
      d.ph = 2'h0;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      if (i_req) begin
        d.st = HS_START;
        d.stage = SCB_STG_ADDR_W;
        d.rw = i_rw;
        d.dev = i_dev_addr;
        d.rega = i_reg_addr;
        d.wd = i_wdata;
        d.nack = 1'b0;
      end
    end else if (!adv) begin
      d.qc = tick ? q.qc : q.qc + SCB_QCNT_W'(1);
    end else begin
      d.qc = '0;
      d.ph = q.ph + 2'h1;
      case (q.ph)
        2'h0: d.scl_oe = 1'b0;
        2'h1: begin
          if (q.st == HS_RX) begin
            d.sh = {q.sh[6:0], q.sda_f};
          end
          if (q.st == HS_ACKRX) begin
            d.ackbit = q.sda_f;
          end
        end
        2'h2: begin
          if (q.st == HS_START) begin
            d.sda_oe = 1'b1;
          end else if (q.st == HS_STOP) begin
            d.sda_oe = 1'b0;
          end else begin
            d.scl_oe = 1'b1;
          end
        end
        default: begin
          case (q.st)
            HS_START: begin
              d.scl_oe = 1'b1;
              d.st = HS_TX;
              d.bitc = 3'h0;
              d.sh = {q.dev, (q.stage == SCB_STG_ADDR_R)};
            end
            HS_TX: begin
              if (q.bitc == SCB_LAST_BIT) begin
                d.st = HS_ACKRX;
              end else begin
                d.bitc = q.bitc + 3'h1;
                d.sh = {q.sh[6:0], 1'b0};
              end
            end
            HS_ACKRX: begin
              d.bitc = 3'h0;
              if (q.ackbit) begin
                d.nack = 1'b1;
                d.st = HS_STOP;
              end else if (q.stage == SCB_STG_ADDR_W) begin
                d.stage = SCB_STG_PTR;
                d.sh = q.rega;
                d.st = HS_TX;
              end else if (q.stage == SCB_STG_PTR && q.rw == SCB_RW_READ) begin
                d.stage = SCB_STG_ADDR_R;
                d.st = HS_START;
              end else if (q.stage == SCB_STG_PTR) begin
                d.stage = SCB_STG_DATA;
                d.sh = q.wd;
                d.st = HS_TX;
              end else if (q.stage == SCB_STG_ADDR_R) begin
                d.st = HS_RX;
              end else begin
                d.st = HS_STOP;
              end
            end
            HS_RX: begin
              if (q.bitc == SCB_LAST_BIT) begin
                d.st = HS_ACKTX;
                d.rdata = q.sh;
              end else begin
                d.bitc = q.bitc + 3'h1;
              end
            end
            HS_ACKTX: d.st = HS_STOP;
            HS_STOP: begin
              d.st = HS_IDLE;
              d.done = 1'b1;
            end
            default: d.st = HS_IDLE;
          endcase
          // Next bit's data is set up while the clock is low
          case (d.st)
            HS_TX: d.sda_oe = ~d.sh[7];
            HS_STOP: d.sda_oe = 1'b1;
            default: d.sda_oe = 1'b0;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= HS_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = q.sda_oe;
  assign o_busy = (q.st != HS_IDLE);
  assign o_done = q.done;
  assign o_nack = q.nack;
  assign o_rdata = q.rdata;

endmodule : scb_host_end

/* File: core/scb_if.sv */
// Two-wire bus carrier with open-drain wire resolution
`timescale 1ns/100ps
interface scb_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;

  // Pull-up wins unless some enabled driver pulls low
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
    output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
    output host_sda_o, output host_sda_oe);
endinterface : scb_if

/* File: core/scb_pkg.sv */
// Shared constants and types for the serial control bus target and its host
package scb_pkg;

  // Clock and bit timing
  localparam int SCB_SYS_MHZ = 25;
  localparam int SCB_HOST_QTR_NS = 2500;
  localparam int SCB_HOST_QTR_CYC =
    (SCB_HOST_QTR_NS * SCB_SYS_MHZ + 999) / 1000;
  localparam int SCB_QCNT_W = 12;

  // Byte framing
  localparam logic [3:0] SCB_BYTE_BITS = 4'h8;
  localparam logic [2:0] SCB_LAST_BIT = 3'h7;
  localparam logic SCB_RW_WRITE = 1'b0;
  localparam logic SCB_RW_READ = 1'b1;

  // Device configuration registers reached over the bus
  localparam int SCB_REG_COUNT = 4;
  localparam int SCB_REG_IDX_W = 2;
  localparam logic [7:0] SCB_REG_ID = 8'h00;
  localparam int SCB_ID_SEL_BIT = 0;
  localparam logic [7:0] SCB_REG_RESET = 8'h00;

  // Strap level bands: 8-bit code of strap voltage over supply
  localparam int SCB_BANDS = 8;
  localparam logic [6:0][7:0] SCB_BAND_EDGE = {
    8'hE4, 8'hBA, 8'h9D, 8'h7F, 8'h62, 8'h45, 8'h1B};
  localparam logic [7:0][6:0] SCB_ADDR_TABLE = {
    7'h1A, 7'h18, 7'h16, 7'h14, 7'h12, 7'h10, 7'h0E, 7'h0C};

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ADDR = 7'h02,
    DS_AACK = 7'h04,
    DS_WR = 7'h08,
    DS_WACK = 7'h10,
    DS_RD = 7'h20,
    DS_RACK = 7'h40
  } scb_dev_st_type;

  typedef enum logic [6:0] {
    HS_IDLE = 7'h01,
    HS_START = 7'h02,
    HS_TX = 7'h04,
    HS_ACKRX = 7'h08,
    HS_RX = 7'h10,
    HS_ACKTX = 7'h20,
    HS_STOP = 7'h40
  } scb_host_st_type;

  // Host sequence stages
  localparam logic [2:0] SCB_STG_ADDR_W = 3'h0;
  localparam logic [2:0] SCB_STG_PTR = 3'h1;
  localparam logic [2:0] SCB_STG_DATA = 3'h2;
  localparam logic [2:0] SCB_STG_ADDR_R = 3'h3;

endpackage : scb_pkg
